// ### bench/serial_partner.sv
// far-side model: external shift register in mode 0, remote uart transmitter otherwise
// assumes a pull-up on the data line, so it idles high whenever nothing drives it
`timescale 1ns/1ps
module serial_partner (
    input wire logic clk_i,
    input wire logic sclk_i,
    output logic pin_o
);
    logic [7:0] sh = 8'h00;
    logic en = 1'b0;
    logic last = 1'b1;
    logic line = 1'b1;
    // lsb is offered first and moves on only after a rising shift clock
    assign pin_o = en ? sh[0] : line;
    always @(posedge clk_i) begin
        last <= sclk_i;
        if (en && sclk_i && !last) begin
            sh <= sh >> 1;
        end
    end
    task automatic load(input logic [7:0] v);
        sh <= v;
        en <= 1'b1;
    endtask
    task automatic stop();
        en <= 1'b0;
    endtask
    // each bit is held one full bit period, stop level restored afterwards
    task automatic send(input logic [10:0] f, input int n, input int p);
        for (int i = 0; i < n; i++) begin
            line <= f[i];
            repeat (p) @(posedge clk_i);
        end
        line <= 1'b1;
        @(posedge clk_i);
    endtask
endmodule

// ### bench/test_serial_port.sv
// testbench for the serial port engine: wishbone tasks, pin capture, expected-value queue
// assumes timer pulses every 2 and 3 clocks, so bits last 32 and 48 clocks in modes 1 and 3
`timescale 1ns/1ps
module test_serial_port;
    import serial_port_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, t1 = 0, t2 = 0;
    logic pin, pin_o, oe, out, irq, sys, ack;
    logic [7:0] adr = 8'h00;
    logic [7:0] b, c;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] rd;
    logic [31:0] expq[$];
    logic [10:0] got;
    int miscompares = 0, checks = 0, cycles = 0;
    always #12.5 clk_i = ~clk_i;
    serial_port serial_port_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd),
        .wb_ack_o(ack), .timer1_ovf_i(t1), .timer2_ovf_i(t2), .serial_data_pin_i(pin),
        .serial_data_pin_o(pin_o), .serial_data_pin_oe_o(oe), .serial_out_pin_o(out),
        .serial_irq_o(irq), .sysflag_irq_o(sys));
    serial_partner serial_partner_i (.clk_i(clk_i), .sclk_i(out), .pin_o(pin));
    task automatic results();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask
    // timers and the hang limit; a run needs well under 20000 clocks
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        t1 <= (cycles % 2 == 0);
        t2 <= (cycles % 3 == 0);
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end
    always @(posedge clk_i) begin
        if (ack && !we) begin
            check(rd, expq.pop_front());
        end
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        dat <= {24'h00_0000, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        expq.push_back({24'h00_0000, e});
        wb(1'b0, a, 8'h00);
    endtask
    // mode 0 transmit: data seen at every rising shift clock, rise spacing 2h clocks
    task automatic m0tx(input logic [7:0] v, input int h);
        int t;
        t = 0;
        wb(1'b1, 8'h04, v);
        for (int i = 0; i < 8; i++) begin
            while (out !== 1'b0) @(posedge clk_i);
            while (out !== 1'b1) @(posedge clk_i);
            check(32'({oe, pin_o}), {31'h0000_0001, v[i]});
            if (i > 0) check(cycles - t, 2 * h);
            t = cycles;
        end
        repeat (3) @(posedge clk_i);
    endtask
    task automatic cap(input int n, input int p);
        while (out !== 1'b0) @(posedge clk_i);
        repeat (p / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            got[i] = out;
            repeat (p) @(posedge clk_i);
        end
    endtask
    initial begin
        void'($urandom(98));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rdx(8'h00, 8'h00);
        rdx(8'h08, 8'h00);
        rdx(8'h14, 8'h00);
        b = $urandom;
        m0tx(b, 6);
        check(32'({sys, irq}), 32'h0000_0001);
        rdx(8'h00, 8'h02);
        wb(1'b1, 8'h00, 8'h00);
        wb(1'b1, 8'h10, 8'h03);
        wb(1'b1, 8'h08, 8'h20);
        m0tx(~b, 2);
        check(32'({sys, irq}), 32'h0000_0002);
        wb(1'b1, 8'h10, 8'h00);
        $display("mode 0 transmit done");
        b = $urandom;
        serial_partner_i.load(b);
        wb(1'b1, 8'h00, 8'h30);
        // the transmit done that the write just cleared has left the line, so this waits for receive done
        do @(posedge clk_i); while (irq !== 1'b1);
        serial_partner_i.stop();
        rdx(8'h04, b);
        rdx(8'h00, 8'h31);
        $display("mode 0 receive done");
        wb(1'b1, 8'h00, 8'h40);
        b = $urandom;
        wb(1'b1, 8'h04, b);
        cap(10, 32);
        check(32'(got[9:0]), 32'({1'b1, b, 1'b0}));
        rdx(8'h00, 8'h42);
        wb(1'b1, 8'h00, 8'h40);
        serial_partner_i.send({2'b00, b, 1'b0}, 10, 32);
        rdx(8'h00, 8'h40);
        $display("mode 1 transmit done");
        c = $urandom;
        wb(1'b1, 8'h00, 8'h50);
        serial_partner_i.send({2'b01, b, 1'b0}, 10, 32);
        serial_partner_i.send({2'b01, c, 1'b0}, 10, 32);
        rdx(8'h04, b);
        rdx(8'h00, 8'h55);
        wb(1'b1, 8'h0C, 8'h40);
        wb(1'b1, 8'h00, 8'h50);
        serial_partner_i.send({2'b00, c, 1'b0}, 10, 32);
        rdx(8'h00, 8'hD1);
        wb(1'b1, 8'h00, 8'hD0);
        serial_partner_i.send({2'b01, c, 1'b0}, 10, 32);
        rdx(8'h00, 8'hD5);
        wb(1'b1, 8'h00, 8'h50);
        rdx(8'h00, 8'h50);
        wb(1'b1, 8'h0C, 8'h00);
        wb(1'b1, 8'h00, 8'h70);
        serial_partner_i.send({2'b00, c, 1'b0}, 10, 32);
        rdx(8'h00, 8'h70);
        $display("mode 1 receive done");
        wb(1'b1, 8'h08, 8'h01);
        wb(1'b1, 8'h00, 8'hF0);
        serial_partner_i.send({2'b10, b, 1'b0}, 11, 48);
        rdx(8'h00, 8'hF0);
        serial_partner_i.send({2'b11, c, 1'b0}, 11, 48);
        rdx(8'h04, c);
        rdx(8'h00, 8'hF5);
        $display("mode 3 receive done");
        wb(1'b1, 8'h08, 8'h04);
        wb(1'b1, 8'h00, 8'h88);
        wb(1'b1, 8'h04, b);
        cap(11, 16);
        check(32'(got), 32'({2'b11, b, 1'b0}));
        rdx(8'h00, 8'h8A);
        wb(1'b1, 8'h08, 8'h02);
        wb(1'b1, 8'h04, c);
        cap(11, 32);
        check(32'(got), 32'({2'b11, c, 1'b0}));
        wb(1'b1, 8'h08, 8'h00);
        wb(1'b1, 8'h04, ~c);
        cap(11, 64);
        check(32'(got), 32'({2'b11, ~c, 1'b0}));
        $display("mode 2 transmit done");
        results();
    end
endmodule

// ### hw/bit_clock_gen.sv
// bit clock generator: mode 0 half-period ticks and 16x sample ticks
// assumes timer overflow inputs are one-cycle pulses synchronous to clk_i
`timescale 1ns/1ps
module bit_clock_gen
    import serial_port_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire rate_cfg_t cfg_i,
    input wire logic timer1_ovf_i,
    input wire logic timer2_ovf_i,
    output logic m0_tick_o,
    output logic sample_tick_o
);
    typedef struct packed {
        logic [5:0] cnt;
        logic m0_tick;
        logic sample_tick;
    } gen_state_t;

    gen_state_t st_q, st_d;
    logic [5:0] limit;

    always_comb begin
        st_d = st_q;
        limit = 6'h01;
        if (cfg_i.mode == 2'b00) begin
            // half of the shift clock period
            limit = cfg_i.triple ? 6'(`M0_DIV_FAST / 2) : 6'(`M0_DIV_SLOW / 2);
        end else if (cfg_i.m2_rate == 2'b10) begin
            limit = `M2_DIV_16;
        end else if (cfg_i.m2_rate == 2'b01) begin
            limit = `M2_DIV_32;
        end else begin
            limit = `M2_DIV_64;
        end
        st_d.m0_tick = 1'b0;
        st_d.sample_tick = 1'b0;
        if (st_q.cnt >= limit - 6'h01) begin
            st_d.cnt = 6'h00;
        end else begin
            st_d.cnt = st_q.cnt + 6'h01;
        end
        if (cfg_i.mode == 2'b00) begin
            st_d.m0_tick = (st_q.cnt >= limit - 6'h01);
        end else if (cfg_i.mode == 2'b10) begin
            // fixed system clock fraction
            st_d.sample_tick = (st_q.cnt >= limit - 6'h01);
        end else begin
            // timer overflow rate, one of two timers
            st_d.sample_tick = cfg_i.timer_sel ? timer2_ovf_i : timer1_ovf_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign m0_tick_o = st_q.m0_tick;
    assign sample_tick_o = st_q.sample_tick;
endmodule

// ### hw/serial_port.sv
// serial port engine for the standard modes 0 to 3 with wishbone register access
// assumes a classic wishbone master on clk_i and timer overflow pulses from outside
// Operation
// - mode 0 moves 8 bits lsb first on data pin, clock on out pin
// - mode 0 shift clock is system clock over 12 or over 4
// - mode 0 buffer write shifts out on rising edges, done after eighth
// - transmit done may be routed to system flag interrupt by two gates
// - mode 0 receive starts on enable and no receive done, preloads 1111110
// - mode 0 receive samples on falling edges, done after eighth
// - mode 1 frame: start, 8 data lsb first, stop into ninth bit
// - mode 1 bit rate from overflow of one of two timers
// - async transmit begins on next transmit bit clock, one period per bit
// - mode 1 transmit done set after eighth data bit
// - mode 1 receive starts on falling pin edge, stop into ninth bit
// - modes 2 and 3 frames: 11 bits with ninth from transmit ninth bit
// - mode 2 rate clock over 16, 32 or 64; mode 3 timer overflow
// - modes 2, 3 buffer write loads ninth bit; done after ninth bit
// - modes 2, 3 receive done after ninth bit, stored as ninth bit
// - async receive needs receive enable and a falling start edge
// - missing stop bit sets framing error flag
// - control bit 7 is framing error or mode bit by framing select
// - framing error flag cleared only by software
// - modes 2, 3 with address filter: receive done only if ninth bit 1
// - mode 1 filter needs valid stop; filter ignored in mode 0
// - buffer write loads transmit register; read returns separate receive register
// - receiver double buffered; byte lost if first still unread
`timescale 1ns/1ps
module serial_port
    import serial_port_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic timer1_ovf_i,
    input wire logic timer2_ovf_i,
    input wire logic serial_data_pin_i,
    output logic serial_data_pin_o,
    output logic serial_data_pin_oe_o,
    output logic serial_out_pin_o,
    output logic serial_irq_o,
    output logic sysflag_irq_o
);
    typedef struct packed {
        logic sm0;
        logic sm1;
        logic filt;
        logic ren;
        logic tb8;
        logic rb8;
        logic ti;
        logic ri;
        logic fe;
        logic triple;
        logic timer_sel;
        logic [1:0] m2_rate;
        logic fsel;
        logic gate_a;
        logic gate_b;
        logic [7:0] rx_buf;
        m0_state_t m0;
        logic [7:0] m0_shift;
        logic [2:0] m0_cnt;
        logic tx_pend;
        logic tx_busy;
        logic [9:0] tx_shift;
        logic [3:0] tx_bits;
        logic [3:0] tx_div;
        rx_state_t rx;
        logic [3:0] rx_tick;
        logic [3:0] rx_bits;
        logic [8:0] rx_shift;
        logic rx_prev;
        logic out_pin;
        logic data_o;
        logic data_oe;
        logic ser_irq;
        logic sys_irq;
        logic ack;
        logic [31:0] dat;
    } port_state_t;

    port_state_t st_q, st_d;
    rate_cfg_t rate_cfg;
    logic m0_tick, sample_tick;
    logic req, wr, wr_ctrl, wr_buf;
    logic [1:0] mode;
    logic tx_bit_tick, ninth_rx, stop_ok, accept;

    assign mode = {st_q.sm0, st_q.sm1};
    assign rate_cfg = '{mode: mode, triple: st_q.triple, timer_sel: st_q.timer_sel,
                        m2_rate: st_q.m2_rate};

    bit_clock_gen u_clk (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cfg_i(rate_cfg),
        .timer1_ovf_i(timer1_ovf_i),
        .timer2_ovf_i(timer2_ovf_i),
        .m0_tick_o(m0_tick),
        .sample_tick_o(sample_tick)
    );

    // a request is taken once; the ack cycle blocks a second take
    assign req = wb_cyc_i && wb_stb_i && !st_q.ack;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign wr_ctrl = wr && (wb_adr_i == `OFF_CTRL);
    assign wr_buf = wr && (wb_adr_i == `OFF_BUF);
    assign tx_bit_tick = sample_tick && (st_q.tx_div == 4'hF);
    assign ninth_rx = st_q.rx_shift[8];
    assign stop_ok = serial_data_pin_i;
    // filter: mode 1 needs a valid stop, modes 2 and 3 a ninth bit of 1
    assign accept = !st_q.filt || ((mode == 2'b01) ? stop_ok : ninth_rx);

    always_comb begin
        st_d = st_q;
        st_d.ack = req;
        st_d.dat = 32'h0000_0000;
        // register reads
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                `OFF_CTRL: st_d.dat[7:0] = {st_q.fsel ? st_q.fe : st_q.sm0, st_q.sm1,
                    st_q.filt, st_q.ren, st_q.tb8, st_q.rb8, st_q.ti, st_q.ri};
                `OFF_BUF: st_d.dat[7:0] = st_q.rx_buf;
                `OFF_CFG: begin
                    st_d.dat[`CFG_TRIPLE] = st_q.triple;
                    st_d.dat[`CFG_M2_RATE_LO +: 2] = st_q.m2_rate;
                    st_d.dat[`CFG_TIMER_SEL] = st_q.timer_sel;
                end
                `OFF_PWR: st_d.dat[`PWR_FRAMING_SEL] = st_q.fsel;
                `OFF_ROUTE: st_d.dat[1:0] = {st_q.gate_b, st_q.gate_a};
                default: st_d.dat = 32'h0000_0000;
            endcase
        end
        // register writes; hardware sets below still win
        if (wr_ctrl) begin
            if (st_q.fsel) begin
                st_d.fe = wb_dat_i[`CTRL_FE_SM0];
            end else begin
                st_d.sm0 = wb_dat_i[`CTRL_FE_SM0];
            end
            st_d.sm1 = wb_dat_i[`CTRL_SM1];
            st_d.filt = wb_dat_i[`CTRL_ADDR_FILT];
            st_d.ren = wb_dat_i[`CTRL_REN];
            st_d.tb8 = wb_dat_i[`CTRL_TB8];
            st_d.rb8 = wb_dat_i[`CTRL_RB8];
            st_d.ti = wb_dat_i[`CTRL_TI];
            st_d.ri = wb_dat_i[`CTRL_RI];
        end
        if (wr && wb_adr_i == `OFF_CFG) begin
            st_d.triple = wb_dat_i[`CFG_TRIPLE];
            st_d.m2_rate = wb_dat_i[`CFG_M2_RATE_LO +: 2];
            st_d.timer_sel = wb_dat_i[`CFG_TIMER_SEL];
        end
        if (wr && wb_adr_i == `OFF_PWR) begin
            st_d.fsel = wb_dat_i[`PWR_FRAMING_SEL];
        end
        if (wr && wb_adr_i == `OFF_ROUTE) begin
            st_d.gate_a = wb_dat_i[`ROUTE_GATE_A];
            st_d.gate_b = wb_dat_i[`ROUTE_GATE_B];
        end

        // mode 0 synchronous shift engine
        unique case (st_q.m0)
            M0_IDLE: begin
                st_d.data_oe = 1'b0;
                if (mode == 2'b00 && wr_buf) begin
                    st_d.m0_shift = wb_dat_i[7:0];
                    st_d.m0_cnt = 3'd0;
                    st_d.out_pin = 1'b0;
                    st_d.data_o = wb_dat_i[0];
                    st_d.data_oe = 1'b1;
                    st_d.m0 = M0_TXLO;
                end else if (mode == 2'b00 && st_q.ren && !st_q.ri) begin
                    st_d.m0_shift = `M0_RX_PRELOAD;
                    st_d.m0_cnt = 3'd0;
                    st_d.m0 = M0_RXLOAD;
                end
            end
            M0_TXLO: if (m0_tick) begin
                st_d.out_pin = 1'b1;
                if (st_q.m0_cnt == 3'd7) begin
                    st_d.m0 = M0_IDLE; // eighth rising edge
                end else begin
                    st_d.m0_cnt = st_q.m0_cnt + 3'd1;
                    st_d.m0 = M0_TXHI;
                end
            end
            M0_TXHI: if (m0_tick) begin
                st_d.out_pin = 1'b0;
                st_d.m0_shift = {1'b0, st_q.m0_shift[7:1]};
                st_d.data_o = st_q.m0_shift[1]; // lsb first
                st_d.m0 = M0_TXLO;
            end
            M0_RXLOAD: begin
                st_d.out_pin = 1'b1;
                st_d.m0 = M0_RXHI; // receive active one clock later
            end
            M0_RXHI: if (m0_tick) begin
                st_d.out_pin = 1'b0;
                st_d.m0_shift = {serial_data_pin_i, st_q.m0_shift[7:1]};
                if (st_q.m0_cnt == 3'd7) begin
                    st_d.m0 = M0_IDLE;
                end else begin
                    st_d.m0_cnt = st_q.m0_cnt + 3'd1;
                    st_d.m0 = M0_RXLO;
                end
            end
            M0_RXLO: if (m0_tick) begin
                st_d.out_pin = 1'b1;
                st_d.m0 = M0_RXHI;
            end
        endcase
        if (st_q.m0 == M0_TXLO && m0_tick && st_q.m0_cnt == 3'd7) begin
            st_d.ti = 1'b1;
        end
        if (st_q.m0 == M0_RXHI && m0_tick && st_q.m0_cnt == 3'd7) begin
            st_d.ri = 1'b1;
            st_d.rx_buf = {serial_data_pin_i, st_q.m0_shift[7:1]};
            st_d.out_pin = 1'b1;
        end

        // asynchronous transmitter
        if (sample_tick) begin
            st_d.tx_div = st_q.tx_div + 4'h1;
        end
        if (mode != 2'b00 && wr_buf && !st_q.tx_busy) begin
            st_d.tx_pend = 1'b1;
            // ninth position holds tb8 in modes 2, 3, a stop bit in mode 1
            st_d.tx_shift = {1'b1, (mode == 2'b01) ? 1'b1 : st_q.tb8, wb_dat_i[7:0]};
        end
        if (mode != 2'b00 && tx_bit_tick) begin
            if (st_q.tx_pend) begin
                st_d.tx_pend = 1'b0;
                st_d.tx_busy = 1'b1;
                st_d.out_pin = 1'b0; // start bit on the next bit clock edge
                st_d.tx_bits = (mode == 2'b01) ? 4'd9 : 4'd10;
            end else if (st_q.tx_busy) begin
                if (st_q.tx_bits == 4'd0) begin
                    st_d.tx_busy = 1'b0;
                end else begin
                    st_d.out_pin = st_q.tx_shift[0];
                    st_d.tx_shift = {1'b1, st_q.tx_shift[9:1]};
                    st_d.tx_bits = st_q.tx_bits - 4'd1;
                    if (st_q.tx_bits == 4'd1) begin
                        st_d.ti = 1'b1; // last data bit sent
                    end
                end
            end
        end
        if (mode != 2'b00 && !st_q.tx_busy && !st_q.tx_pend) begin
            st_d.out_pin = 1'b1;
        end

        // asynchronous receiver, 16 samples per bit
        if (sample_tick) begin
            st_d.rx_prev = serial_data_pin_i;
        end
        unique case (st_q.rx)
            RX_IDLE: begin
                st_d.rx_tick = 4'h0;
                st_d.rx_bits = 4'h0;
                if (mode != 2'b00 && st_q.ren && sample_tick && st_q.rx_prev &&
                    !serial_data_pin_i) begin
                    st_d.rx = RX_START;
                end
            end
            RX_START, RX_DATA, RX_STOP: if (sample_tick) begin
                st_d.rx_tick = st_q.rx_tick + 4'h1;
                if (st_q.rx_tick == `SAMPLE_MID) begin
                    if (st_q.rx == RX_START) begin
                        // a glitch that is high again at mid bit is not a start
                        st_d.rx = serial_data_pin_i ? RX_IDLE : RX_DATA;
                    end else if (st_q.rx == RX_DATA) begin
                        st_d.rx_shift = {serial_data_pin_i, st_q.rx_shift[8:1]};
                        st_d.rx_bits = st_q.rx_bits + 4'h1;
                        if (st_q.rx_bits == ((mode == 2'b01) ? 4'd7 : 4'd8)) begin
                            st_d.rx = RX_STOP;
                        end
                    end else begin
                        st_d.rx = RX_IDLE;
                    end
                end
            end
            default: st_d.rx = RX_IDLE;
        endcase
        if (st_q.rx == RX_STOP && sample_tick && st_q.rx_tick == `SAMPLE_MID) begin
            if (!stop_ok) begin
                st_d.fe = 1'b1;
            end
            // unread byte stays; the new one is dropped
            if (!st_q.ri && accept) begin
                st_d.ri = 1'b1;
                if (mode == 2'b01) begin
                    st_d.rx_buf = st_q.rx_shift[8:1];
                    st_d.rb8 = stop_ok;
                end else begin
                    st_d.rx_buf = st_q.rx_shift[7:0];
                    st_d.rb8 = ninth_rx;
                end
            end
        end
        if (mode == 2'b00) begin
            st_d.rx = RX_IDLE;
            st_d.tx_pend = 1'b0;
            st_d.tx_busy = 1'b0;
        end else begin
            st_d.m0 = M0_IDLE;
            st_d.data_oe = 1'b0;
        end

        // transmit done goes to the system flag line when both gates are set
        st_d.sys_irq = st_q.ti && st_q.gate_a && st_q.gate_b;
        st_d.ser_irq = st_q.ri || (st_q.ti && !(st_q.gate_a && st_q.gate_b));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
            st_q.m0 <= M0_IDLE;
            st_q.rx <= RX_IDLE;
            st_q.out_pin <= 1'b1;
            st_q.rx_prev <= 1'b1;
            st_q.rx_buf <= `RX_BUF_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign wb_dat_o = st_q.dat;
    assign wb_ack_o = st_q.ack;
    assign serial_data_pin_o = st_q.data_o;
    assign serial_data_pin_oe_o = st_q.data_oe;
    assign serial_out_pin_o = st_q.out_pin;
    assign serial_irq_o = st_q.ser_irq;
    assign sysflag_irq_o = st_q.sys_irq;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic sw_clr_ti, sw_clr_ri, sw_clr_fe;
    assign sw_clr_ti = wr_ctrl && !wb_dat_i[`CTRL_TI];
    assign sw_clr_ri = wr_ctrl && !wb_dat_i[`CTRL_RI];
    assign sw_clr_fe = wr_ctrl && st_q.fsel && !wb_dat_i[`CTRL_FE_SM0];

    sequence s_rx_load;
        st_q.m0 == M0_RXLOAD && st_q.m0_shift == `M0_RX_PRELOAD;
    endsequence
    sequence s_rx_active;
        st_q.m0 == M0_RXHI && st_q.out_pin;
    endsequence

    a_ti_sticky: assert property (st_q.ti && !sw_clr_ti |=> st_q.ti)
        else $error("transmit done dropped without software clear");
    a_ri_sticky: assert property (st_q.ri && !sw_clr_ri |=> st_q.ri)
        else $error("receive done dropped without software clear");
    a_fe_sticky: assert property (st_q.fe && !sw_clr_fe |=> st_q.fe)
        else $error("framing error cleared by hardware");
    a_m0_rx_start: assert property (st_q.m0 == M0_IDLE && mode == 2'b00 && st_q.ren &&
        !st_q.ri && !wr_buf && !wr_ctrl |=> s_rx_load ##1 s_rx_active)
        else $error("mode 0 receive did not preload and activate");
    a_m0_fast_clock: assert property (mode == 2'b00 && st_q.triple && m0_tick &&
        !wr |=> !m0_tick ##1 m0_tick)
        else $error("fast shift clock half period wrong");
    // no register write for five cycles, so neither the divider nor the mode moves
    a_m0_slow_clock: assert property (mode == 2'b00 && !st_q.triple && m0_tick &&
        !wr ##1 !wr [*4] |=> !m0_tick && !$past(m0_tick) && !$past(m0_tick, 2) &&
        !$past(m0_tick, 3) && !$past(m0_tick, 4) ##1 m0_tick)
        else $error("slow shift clock half period wrong");
    a_bad_stop_fe: assert property (st_q.rx == RX_STOP && sample_tick &&
        st_q.rx_tick == `SAMPLE_MID && !serial_data_pin_i |=> st_q.fe)
        else $error("missing stop bit did not set framing error");
    a_filter_ninth: assert property (st_q.rx == RX_STOP && sample_tick &&
        st_q.rx_tick == `SAMPLE_MID && mode[1] && st_q.filt && !ninth_rx &&
        !st_q.ri && !wr_ctrl |=> !st_q.ri)
        else $error("filtered data byte raised receive done");
    a_tx_start_bit: assert property (mode != 2'b00 && tx_bit_tick && st_q.tx_pend
        |=> !st_q.out_pin && st_q.tx_busy)
        else $error("asynchronous start bit missing");
    a_sysflag_route: assert property (st_q.ti && st_q.gate_a && st_q.gate_b
        |=> sysflag_irq_o ##0 (serial_irq_o == $past(st_q.ri)))
        else $error("transmit done not routed to system flag line");
endmodule

// ### hw/serial_port_cfg.svh
// serial port engine: register offsets, field positions, reset values, divider counts
// assumes byte addressed wishbone with one aligned 32-bit word per register
`ifndef SERIAL_PORT_CFG_SVH
`define SERIAL_PORT_CFG_SVH

// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_BUF 8'h04
`define OFF_CFG 8'h08
`define OFF_PWR 8'h0C
`define OFF_ROUTE 8'h10

// port_control_register fields
`define CTRL_FE_SM0 7
`define CTRL_SM1 6
`define CTRL_ADDR_FILT 5
`define CTRL_REN 4
`define CTRL_TB8 3
`define CTRL_RB8 2
`define CTRL_TI 1
`define CTRL_RI 0

// port_config_register fields
`define CFG_TIMER_SEL 0
`define CFG_M2_RATE_LO 1
`define CFG_TRIPLE 5

// power_control_register fields
`define PWR_FRAMING_SEL 6

// flag route register fields
`define ROUTE_GATE_A 0
`define ROUTE_GATE_B 1

// reset values
`define CTRL_RST 8'h00
`define CFG_RST 8'h00
`define RX_BUF_RST 8'h00

// mode 0 receive shift preload (1111110)
`define M0_RX_PRELOAD 8'h7E

// dividers in system clocks
`define M0_DIV_SLOW 12
`define M0_DIV_FAST 4
`define OVERSAMPLE 16
`define SAMPLE_MID 4'h7
`define M2_DIV_64 6'h04
`define M2_DIV_32 6'h02
`define M2_DIV_16 6'h01

`endif

// ### hw/serial_port_pkg.sv
// serial port engine: shared types
// assumes serial_port_cfg.svh is on the include path
package serial_port_pkg;
    `include "serial_port_cfg.svh"

    typedef enum logic [5:0] {
        M0_IDLE = 6'b00_0001,
        M0_TXLO = 6'b00_0010,
        M0_TXHI = 6'b00_0100,
        M0_RXLOAD = 6'b00_1000,
        M0_RXLO = 6'b01_0000,
        M0_RXHI = 6'b10_0000
    } m0_state_t;

    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } rx_state_t;

    // bit rate selection handed to the clock generator
    typedef struct packed {
        logic [1:0] mode;
        logic triple;
        logic timer_sel;
        logic [1:0] m2_rate;
    } rate_cfg_t;
endpackage
